// ===== rtl/gsb_regs.v
`timescale 1ns/1ps
`default_nettype none
`include "gsb_defs.vh"

module gsb_regs (
	// Clock, reset and clock enable.
	input wire clk,
	input wire reset,
	input wire clkEn,
	// Register access port from the serial engine.
	input wire [`GSB_ADDR_W-1:0] regAddr,
	input wire regWrite,
	input wire regRead,
	input wire [7:0] regWrData,
	output reg [7:0] regRdData,
	output reg regRdValid,
	// Gain state selection and chain control.
	input wire [1:0] stateSel,
	input wire [7:0] stateZeroSetting,
	input wire wholeChainBypass,
	// Fused trim values.
	input wire [3:0] fusedMainBias,
	input wire [5:0] fusedZtatBias,
	input wire [3:0] fusedPtatBias,
	// Applied gain controls.
	output reg stageOneBypass,
	output reg stageTwoBypass,
	output reg [5:0] stepAtten,
	// Applied stage two bias controls.
	output reg stageTwoBiasMonitorOn,
	output reg stageTwoCrossTrimOn,
	output reg stageTwoIntermodTrimOn,
	output reg stageTwoLowPower,
	output reg [3:0] mainBiasTrim,
	output reg [5:0] ztatBiasTrim,
	output reg [3:0] ptatBiasTrim
);

	wire [7:0] stateOneSetting;
	wire [7:0] stateTwoSetting;
	wire [7:0] stateThreeSetting;
	wire [7:0] biasControl;
	wire [7:0] mainTrimReg;
	wire [7:0] ztatTrimReg;
	wire [7:0] ptatTrimReg;
	reg wrStateOne;
	reg wrStateTwo;
	reg wrStateThree;
	reg wrBiasCtrl;
	reg wrMainTrim;
	reg wrZtatTrim;
	reg wrPtatTrim;
	reg [7:0] rdMux;
	reg [7:0] selSetting;
	reg stageOneBypass_nxt;
	reg stageTwoBypass_nxt;
	reg [5:0] stepAtten_nxt;
	wire [7:0] readbackValue;
	wire trimAllowed;

	// Write decode.
	always @* begin
		wrStateOne = 1'b0;
		wrStateTwo = 1'b0;
		wrStateThree = 1'b0;
		wrBiasCtrl = 1'b0;
		wrMainTrim = 1'b0;
		wrZtatTrim = 1'b0;
		wrPtatTrim = 1'b0;
		if (regAddr == `GSB_OFS_STATE_ONE) begin
			wrStateOne = regWrite;
		end else if (regAddr == `GSB_OFS_STATE_TWO) begin
			wrStateTwo = regWrite;
		end else if (regAddr == `GSB_OFS_STATE_THREE) begin
			wrStateThree = regWrite;
		end else if (regAddr == `GSB_OFS_BIAS_CTRL) begin
			wrBiasCtrl = regWrite;
		end else if (regAddr == `GSB_OFS_MAIN_TRIM) begin
			wrMainTrim = regWrite;
		end else if (regAddr == `GSB_OFS_ZTAT_TRIM) begin
			wrZtatTrim = regWrite;
		end else if (regAddr == `GSB_OFS_PTAT_TRIM) begin
			wrPtatTrim = regWrite;
		end
	end

	// Stored gain states.
	gsb_reg_byte #(
		.RESET_VAL(`GSB_RST_STATE_ONE),
		.WR_MASK(`GSB_WMASK_STATE)
	) stateOneReg (
		.clk(clk),
		.reset(reset),
		.clkEn(clkEn),
		.wrEn(wrStateOne),
		.wrData(regWrData),
		.value(stateOneSetting)
	);

	gsb_reg_byte #(
		.RESET_VAL(`GSB_RST_STATE_TWO),
		.WR_MASK(`GSB_WMASK_STATE)
	) stateTwoReg (
		.clk(clk),
		.reset(reset),
		.clkEn(clkEn),
		.wrEn(wrStateTwo),
		.wrData(regWrData),
		.value(stateTwoSetting)
	);

	gsb_reg_byte #(
		.RESET_VAL(`GSB_RST_STATE_THREE),
		.WR_MASK(`GSB_WMASK_STATE)
	) stateThreeReg (
		.clk(clk),
		.reset(reset),
		.clkEn(clkEn),
		.wrEn(wrStateThree),
		.wrData(regWrData),
		.value(stateThreeSetting)
	);

	// Stage two bias control and trims.
	gsb_reg_byte #(
		.RESET_VAL(`GSB_RST_BIAS_CTRL),
		.WR_MASK(`GSB_WMASK_BIAS_CTRL)
	) biasCtrlReg (
		.clk(clk),
		.reset(reset),
		.clkEn(clkEn),
		.wrEn(wrBiasCtrl),
		.wrData(regWrData),
		.value(biasControl)
	);

	gsb_reg_byte #(
		.RESET_VAL(`GSB_RST_MAIN_TRIM),
		.WR_MASK(`GSB_WMASK_MAIN_TRIM)
	) mainTrimRegInst (
		.clk(clk),
		.reset(reset),
		.clkEn(clkEn),
		.wrEn(wrMainTrim),
		.wrData(regWrData),
		.value(mainTrimReg)
	);

	gsb_reg_byte #(
		.RESET_VAL(`GSB_RST_ZTAT_TRIM),
		.WR_MASK(`GSB_WMASK_ZTAT_TRIM)
	) ztatTrimRegInst (
		.clk(clk),
		.reset(reset),
		.clkEn(clkEn),
		.wrEn(wrZtatTrim),
		.wrData(regWrData),
		.value(ztatTrimReg)
	);

	gsb_reg_byte #(
		.RESET_VAL(`GSB_RST_PTAT_TRIM),
		.WR_MASK(`GSB_WMASK_PTAT_TRIM)
	) ptatTrimRegInst (
		.clk(clk),
		.reset(reset),
		.clkEn(clkEn),
		.wrEn(wrPtatTrim),
		.wrData(regWrData),
		.value(ptatTrimReg)
	);

	// Pick the selected state: a stored one, or the stateZeroSetting input for state zero.
	always @* begin
		case (stateSel)
			`GSB_SEL_STATE_ONE: begin
				selSetting = stateOneSetting;
			end
			`GSB_SEL_STATE_TWO: begin
				selSetting = stateTwoSetting;
			end
			`GSB_SEL_STATE_THREE: begin
				selSetting = stateThreeSetting;
			end
			default: begin
				selSetting = stateZeroSetting;
			end
		endcase
	end

	// Chain bypass overrides the per-stage settings; codes above 24 dB saturate so the attenuator never sees them.
	always @* begin
		stageTwoBypass_nxt = selSetting[`GSB_BIT_STAGE_TWO_BYPASS] | wholeChainBypass;
		stageOneBypass_nxt = selSetting[`GSB_BIT_STAGE_ONE_BYPASS] | wholeChainBypass;
		if (selSetting[`GSB_ATTEN_HI:`GSB_ATTEN_LO] > `GSB_ATTEN_MAX) begin
			stepAtten_nxt = `GSB_ATTEN_MAX;
		end else begin
			stepAtten_nxt = selSetting[`GSB_ATTEN_HI:`GSB_ATTEN_LO];
		end
	end

	// Low bias mode drops both trim currents whatever their enables say.
	assign trimAllowed = ~biasControl[`GSB_BIT_LOW_POWER];

	// Applied outputs are registered so the analog controls never see decode glitches.
	always @(posedge clk) begin
		if (reset) begin
			stageOneBypass <= 1'b0;
			stageTwoBypass <= 1'b0;
			stepAtten <= 6'h00;
			stageTwoBiasMonitorOn <= 1'b0;
			stageTwoCrossTrimOn <= 1'b0;
			stageTwoIntermodTrimOn <= 1'b0;
			stageTwoLowPower <= 1'b0;
			mainBiasTrim <= 4'h0;
			ztatBiasTrim <= 6'h00;
			ptatBiasTrim <= 4'h0;
		end else if (clkEn) begin
			stageOneBypass <= stageOneBypass_nxt;
			stageTwoBypass <= stageTwoBypass_nxt;
			stepAtten <= stepAtten_nxt;
			stageTwoBiasMonitorOn <= biasControl[`GSB_BIT_MONITOR_ON];
			stageTwoLowPower <= biasControl[`GSB_BIT_LOW_POWER];
			stageTwoCrossTrimOn <= biasControl[`GSB_BIT_CROSS_TRIM_ON] & trimAllowed;
			stageTwoIntermodTrimOn <= biasControl[`GSB_BIT_INTERMOD_TRIM_ON] & trimAllowed;
			if (mainTrimReg[`GSB_BIT_USE_FUSED]) begin
				mainBiasTrim <= fusedMainBias;
			end else begin
				mainBiasTrim <= mainTrimReg[`GSB_MAIN_HI:0];
			end
			if (ztatTrimReg[`GSB_BIT_USE_FUSED]) begin
				ztatBiasTrim <= fusedZtatBias;
			end else begin
				ztatBiasTrim <= ztatTrimReg[`GSB_ZTAT_HI:0];
			end
			if (ptatTrimReg[`GSB_BIT_USE_FUSED]) begin
				ptatBiasTrim <= fusedPtatBias;
			end else begin
				ptatBiasTrim <= ptatTrimReg[`GSB_PTAT_HI:0];
			end
		end
	end

	// Readback shows what the stages really get, not what was written.
	assign readbackValue = {stageTwoBypass, stageOneBypass, stepAtten};

	// Read decode; unmapped offsets read zero.
	always @* begin
		rdMux = 8'h00;
		if (regAddr == `GSB_OFS_STATE_ONE) begin
			rdMux = stateOneSetting;
		end else if (regAddr == `GSB_OFS_STATE_TWO) begin
			rdMux = stateTwoSetting;
		end else if (regAddr == `GSB_OFS_STATE_THREE) begin
			rdMux = stateThreeSetting;
		end else if (regAddr == `GSB_OFS_BIAS_CTRL) begin
			rdMux = biasControl;
		end else if (regAddr == `GSB_OFS_MAIN_TRIM) begin
			rdMux = mainTrimReg;
		end else if (regAddr == `GSB_OFS_ZTAT_TRIM) begin
			rdMux = ztatTrimReg;
		end else if (regAddr == `GSB_OFS_PTAT_TRIM) begin
			rdMux = ptatTrimReg;
		end else if (regAddr == `GSB_OFS_READBACK) begin
			rdMux = readbackValue;
		end
	end

	// A read in the same cycle as a write returns the value held before that write.
	always @(posedge clk) begin
		if (reset) begin
			regRdData <= 8'h00;
			regRdValid <= 1'b0;
		end else if (clkEn) begin
			regRdValid <= regRead;
			if (regRead) begin
				regRdData <= rdMux;
			end
		end
	end

endmodule

`default_nettype wire

// ===== rtl/gsb_defs.vh
`ifndef GSB_DEFS_VH
`define GSB_DEFS_VH

// Register offsets.
`define GSB_ADDR_W 15
`define GSB_OFS_STATE_ONE 15'h010B
`define GSB_OFS_STATE_TWO 15'h010C
`define GSB_OFS_STATE_THREE 15'h010D
`define GSB_OFS_BIAS_CTRL 15'h010F
`define GSB_OFS_MAIN_TRIM 15'h0110
`define GSB_OFS_ZTAT_TRIM 15'h0111
`define GSB_OFS_PTAT_TRIM 15'h0112
`define GSB_OFS_READBACK 15'h014A

// Reset values.
`define GSB_RST_STATE_ONE 8'h10
`define GSB_RST_STATE_TWO 8'h08
`define GSB_RST_STATE_THREE 8'h00
`define GSB_RST_BIAS_CTRL 8'h06
`define GSB_RST_MAIN_TRIM 8'h89
`define GSB_RST_ZTAT_TRIM 8'hAA
`define GSB_RST_PTAT_TRIM 8'h83
`define GSB_RST_READBACK 8'h00

// Writable bit masks; bits outside a mask are reserved and read zero.
`define GSB_WMASK_STATE 8'hFF
`define GSB_WMASK_BIAS_CTRL 8'h0F
`define GSB_WMASK_MAIN_TRIM 8'h8F
`define GSB_WMASK_ZTAT_TRIM 8'hBF
`define GSB_WMASK_PTAT_TRIM 8'h8F

// Gain state field positions.
`define GSB_BIT_STAGE_TWO_BYPASS 7
`define GSB_BIT_STAGE_ONE_BYPASS 6
`define GSB_ATTEN_HI 5
`define GSB_ATTEN_LO 0
`define GSB_ATTEN_MAX 6'h18

// Stage two bias control field positions.
`define GSB_BIT_MONITOR_ON 3
`define GSB_BIT_CROSS_TRIM_ON 2
`define GSB_BIT_INTERMOD_TRIM_ON 1
`define GSB_BIT_LOW_POWER 0

// Trim register field positions.
`define GSB_BIT_USE_FUSED 7
`define GSB_MAIN_HI 3
`define GSB_ZTAT_HI 5
`define GSB_PTAT_HI 3

// State selection codes.
`define GSB_SEL_STATE_ZERO 2'h0
`define GSB_SEL_STATE_ONE 2'h1
`define GSB_SEL_STATE_TWO 2'h2
`define GSB_SEL_STATE_THREE 2'h3

`endif

// ===== rtl/gsb_reg_byte.v
`timescale 1ns/1ps
`default_nettype none

module gsb_reg_byte #(
	parameter [7:0] RESET_VAL = 8'h00,
	parameter [7:0] WR_MASK = 8'hFF
) (
	// Clock and reset.
	input wire clk,
	input wire reset,
	input wire clkEn,
	// Write port.
	input wire wrEn,
	input wire [7:0] wrData,
	// Stored value.
	output wire [7:0] value
);

	reg [7:0] value_r;
	wire [7:0] value_nxt;

	// Reserved bits keep their reset value, which is zero for every reserved field here.
	assign value_nxt = (wrData & WR_MASK) | (value_r & ~WR_MASK);

	always @(posedge clk) begin
		if (reset) begin
			value_r <= RESET_VAL;
		end else if (clkEn && wrEn) begin
			value_r <= value_nxt;
		end
	end

	assign value = value_r;

endmodule

`default_nettype wire

// ===== bench/gsb_regs_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module gsb_regs_assertions (
	// Clock and reset.
	input wire logic clk,
	input wire logic reset,
	input wire logic clkEn,
	// Register port.
	input wire logic [14:0] regAddr,
	input wire logic regRead,
	input wire logic [7:0] regRdData,
	input wire logic regRdValid,
	// Applied controls.
	input wire logic wholeChainBypass,
	input wire logic stageOneBypass,
	input wire logic stageTwoBypass,
	input wire logic [5:0] stepAtten,
	input wire logic stageTwoCrossTrimOn,
	input wire logic stageTwoIntermodTrimOn,
	input wire logic stageTwoLowPower
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	property p_rdValid;
		clkEn |=> regRdValid == $past(regRead);
	endproperty
	a_rdValid: assert property (p_rdValid) else $error("read valid pulse wrong");
	property p_readback;
		regRead && clkEn && regAddr == 15'h014A |=>
			regRdData == {$past(stageTwoBypass), $past(stageOneBypass), $past(stepAtten)};
	endproperty
	a_readback: assert property (p_readback) else $error("readback differs from applied controls");
	property p_resCtl;
		regRead && clkEn && regAddr == 15'h010F |=> regRdData[7:4] == 4'h0;
	endproperty
	a_resCtl: assert property (p_resCtl) else $error("control reserved bits not zero");
	property p_resMain;
		regRead && clkEn && regAddr == 15'h0110 |=> regRdData[6:4] == 3'h0;
	endproperty
	a_resMain: assert property (p_resMain) else $error("main trim reserved bits not zero");
	property p_resZtat;
		regRead && clkEn && regAddr == 15'h0111 |=> !regRdData[6];
	endproperty
	a_resZtat: assert property (p_resZtat) else $error("ztat trim reserved bit not zero");
	property p_resPtat;
		regRead && clkEn && regAddr == 15'h0112 |=> regRdData[6:4] == 3'h0;
	endproperty
	a_resPtat: assert property (p_resPtat) else $error("ptat trim reserved bits not zero");
	property p_chain;
		wholeChainBypass && clkEn |=> stageOneBypass && stageTwoBypass;
	endproperty
	a_chain: assert property (p_chain) else $error("chain bypass not applied");
	property p_atten;
		stepAtten <= 6'h18;
	endproperty
	a_atten: assert property (p_atten) else $error("attenuator code above range");
	property p_lowPwr;
		stageTwoLowPower |-> !stageTwoCrossTrimOn && !stageTwoIntermodTrimOn;
	endproperty
	a_lowPwr: assert property (p_lowPwr) else $error("low power left trim on");
endmodule
bind gsb_regs gsb_regs_assertions chk_u (.clk(clk), .reset(reset), .clkEn(clkEn), .regAddr(regAddr),
	.regRead(regRead), .regRdData(regRdData), .regRdValid(regRdValid), .wholeChainBypass(wholeChainBypass),
	.stageOneBypass(stageOneBypass), .stageTwoBypass(stageTwoBypass), .stepAtten(stepAtten),
	.stageTwoCrossTrimOn(stageTwoCrossTrimOn), .stageTwoIntermodTrimOn(stageTwoIntermodTrimOn),
	.stageTwoLowPower(stageTwoLowPower));
`default_nettype wire

// ===== bench/gsb_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module gsb_host_model (
	// Clock.
	input wire logic clk,
	// Register requests.
	output var logic [14:0] regAddr,
	output var logic regWrite,
	output var logic regRead,
	output var logic [7:0] regWrData
);
	initial begin
		regAddr = 15'h0000;
		regWrite = 1'b0;
		regRead = 1'b0;
		regWrData = 8'h00;
	end
	task automatic access(input logic [14:0] a, input logic w, input logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrite <= w;
		regRead <= ~w;
		regWrData <= d;
		@(posedge clk);
		regWrite <= 1'b0;
		regRead <= 1'b0;
		// Idle data is inverted so a late capture cannot pass by luck.
		regWrData <= ~d;
	endtask
endmodule
`default_nettype wire

// ===== bench/gsb_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module gsb_regs_tb_top;
	logic clk, reset, clkEn, regWrite, regRead, regRdValid, wholeChainBypass;
	logic [14:0] regAddr;
	logic [7:0] regWrData, regRdData, stateZeroSetting;
	logic [1:0] stateSel;
	logic [3:0] fusedMainBias, fusedPtatBias, mainBiasTrim, ptatBiasTrim;
	logic [5:0] fusedZtatBias, ztatBiasTrim, stepAtten;
	logic stageOneBypass, stageTwoBypass, stageTwoBiasMonitorOn, stageTwoCrossTrimOn, stageTwoIntermodTrimOn;
	logic stageTwoLowPower;
	int err_total = 0;
	int cmp_count = 0;
	int cycles = 0;
	logic [31:0] seed = 32'h1E5F344C;
	logic [31:0] v;
	logic [7:0] sh [7];
	logic [7:0] expQ [$];
	localparam logic [14:0] OFS [7] = '{15'h010B, 15'h010C, 15'h010D, 15'h010F, 15'h0110, 15'h0111, 15'h0112};
	localparam logic [7:0] RSTV [7] = '{8'h10, 8'h08, 8'h00, 8'h06, 8'h89, 8'hAA, 8'h83};
	localparam logic [7:0] MASK [7] = '{8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'h8F, 8'hBF, 8'h8F};
	gsb_host_model host_u (.clk(clk), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead), .regWrData(regWrData));
	gsb_regs dut_u (.clk(clk), .reset(reset), .clkEn(clkEn), .regAddr(regAddr), .regWrite(regWrite),
		.regRead(regRead), .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
		.stateSel(stateSel), .stateZeroSetting(stateZeroSetting), .wholeChainBypass(wholeChainBypass),
		.fusedMainBias(fusedMainBias), .fusedZtatBias(fusedZtatBias), .fusedPtatBias(fusedPtatBias),
		.stageOneBypass(stageOneBypass), .stageTwoBypass(stageTwoBypass), .stepAtten(stepAtten),
		.stageTwoBiasMonitorOn(stageTwoBiasMonitorOn), .stageTwoCrossTrimOn(stageTwoCrossTrimOn),
		.stageTwoIntermodTrimOn(stageTwoIntermodTrimOn), .stageTwoLowPower(stageTwoLowPower),
		.mainBiasTrim(mainBiasTrim), .ztatBiasTrim(ztatBiasTrim), .ptatBiasTrim(ptatBiasTrim));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task test_done();
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task rd(input logic [14:0] a, input logic [7:0] e);
		host_u.access(a, 1'b0, 8'h00);
		expQ.push_back(e);
	endtask
	task check_out();
		logic [7:0] r;
		r = (stateSel == 2'h0) ? stateZeroSetting : sh[stateSel - 2'h1];
		r[7] = r[7] | wholeChainBypass;
		r[6] = r[6] | wholeChainBypass;
		if (r[5:0] > 6'h18) r[5:0] = 6'h18;
		chk({stageTwoBypass, stageOneBypass, stepAtten}, r, "gain");
		chk({stageTwoBiasMonitorOn, stageTwoCrossTrimOn, stageTwoIntermodTrimOn, stageTwoLowPower},
			{sh[3][3], sh[3][2] & ~sh[3][0], sh[3][1] & ~sh[3][0], sh[3][0]}, "bias");
		chk({mainBiasTrim, ztatBiasTrim, ptatBiasTrim}, {sh[4][7] ? fusedMainBias : sh[4][3:0],
			sh[5][7] ? fusedZtatBias : sh[5][5:0], sh[6][7] ? fusedPtatBias : sh[6][3:0]}, "trim");
		rd(15'h014A, r);
	endtask
	// Read answers are checked in order, away from the edge that launches them.
	always @(negedge clk) begin
		if (regRdValid === 1'b1) begin
			if (expQ.size() > 0) chk(regRdData, expQ.pop_front(), "read");
			else chk(regRdData, 32'hFFFF_FFFF, "unasked read");
		end
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 4000) begin
			err_total++;
			test_done();
		end
	end
	initial begin
		reset = 1'b1;
		clkEn = 1'b1;
		stateSel = 2'h0;
		stateZeroSetting = 8'h00;
		wholeChainBypass = 1'b0;
		fusedMainBias = 4'h0;
		fusedZtatBias = 6'h00;
		fusedPtatBias = 4'h0;
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		for (int i = 0; i < 7; i++) begin
			sh[i] = RSTV[i];
			rd(OFS[i], RSTV[i]);
		end
		rd(15'h0000, 8'h00);
		check_out();
		for (int k = 0; k < 12; k++) begin
			for (int i = 0; i < 7; i++) begin
				v = rnd();
				host_u.access(OFS[i], 1'b1, (k == 0) ? 8'hFF : v[7:0]);
				sh[i] = ((k == 0) ? 8'hFF : v[7:0]) & MASK[i];
				rd(OFS[i], sh[i]);
			end
			host_u.access(15'h014A, 1'b1, 8'hFF);
			v = rnd();
			@(posedge clk);
			stateSel <= k[1:0];
			wholeChainBypass <= k[2];
			stateZeroSetting <= v[15:8];
			fusedMainBias <= v[19:16];
			fusedZtatBias <= v[25:20];
			fusedPtatBias <= v[29:26];
			repeat (3) @(posedge clk);
			#1;
			check_out();
		end
		// A write while the clock enable is low must not land.
		@(posedge clk);
		clkEn <= 1'b0;
		host_u.access(OFS[0], 1'b1, ~sh[0]);
		clkEn <= 1'b1;
		rd(OFS[0], sh[0]);
		// A reset in mid-run brings every register back to its reset value.
		@(posedge clk);
		reset <= 1'b1;
		@(posedge clk);
		reset <= 1'b0;
		for (int i = 0; i < 7; i++) begin
			sh[i] = RSTV[i];
			rd(OFS[i], RSTV[i]);
		end
		check_out();
		repeat (4) @(posedge clk);
		chk(expQ.size(), 32'h0, "reads left");
		test_done();
	end
endmodule
`default_nettype wire
